// ===== hdl/srdg_core_end.sv
// Core end: snoop retry driver and data bus grant qualifier.
// Summary of operation
// - Tristate enabled: retry floats, high or low.
// - Tristate off: retry always driven, valid with enable.
// - Assert retry when snoop demands retry.
// - Update needed: request bus second cycle after ack.
// - Retry from third cycle until after ack.
// - Retry driven negated one cycle after ack.
// - Retry floats two cycles after ack.
// - Enable from second cycle until after ack.
// - Enable negates second cycle after ack.
// - Negated enable: invalid or floating retry.
// - Enable decides drive; wired-OR forms bidirectional line.
// - Tristate setting static, set before reset release.
// - No data request; transfer start implies it.
// - Grant qualified only with busy, retries negated.
// - No data tenure while grant negated.
// - Grant not sampled before own transfer start.
// - Write-only hint reorders writes before reads.
// - Address acknowledge ends the address phase.
// - Write-only seen only on qualified grant, pending write.
`timescale 1ns/100ps
`default_nettype none
`include "srdg_map.svh"
module srdg_core_end import srdg_pkg::*; (
   input  wire logic ref_clk,      // Bus clock.
   input  wire logic arst_n,       // Asynchronous reset, active low.
   srdg_if.core      bus,          // Link to the arbiter end.
   input  wire logic snoopRetry,   // Snoop says retry, with start.
   input  wire logic snoopUpdate,  // Snoop needs a memory update.
   input  wire logic xferReq,      // Request a transfer, held.
   input  wire logic xferWrite,    // Requested transfer writes.
   input  wire logic xferAddrOnly, // Requested transfer is address only.
   output logic      xferTaken,    // Pulse: start of the requested transfer issued, not of a copy-back.
   output logic      tenureStart,  // Pulse: data tenure begins.
   output logic      tenureWrite,  // Current data tenure is a write.
   output logic      tenureDone    // Pulse: data tenure ended.
);
   localparam int QD = `SRDG_QDEPTH; // Pending data tenure slots.

   srdg_retry_e state_q;   // Retry sequencer state.
   srdg_retry_e state_d;   // Its next value.
   logic [1:0]  cnt_q;     // Cycles since the snooped start.
   logic [1:0]  cnt_d;     // Its next value.
   logic        ackSeen_q; // Acknowledge came before retry rose.
   logic        ackSeen_d; // Its next value.
   logic        update_q;  // Retry needs a copy-back.
   logic        copyPend_q;  // Copy-back transfer outstanding.
   logic        ownAddr_q;   // Own address phase open.
   logic        qWr_q [QD];  // Kind per pending tenure, 1 = write.
   srdg_cnt_t   qCnt_q;      // Pending tenures.
   logic        launch;      // Transfer start goes out this edge.
   logic        launchWr;    // The launched transfer writes.
   logic        launchData;  // The launched transfer has data.
   logic        qualGrant;   // Qualified data bus grant.
   logic [1:0]  selIdx;      // Entry served by the grant.
   logic [1:0]  enqPos;      // Slot for a new entry.
   logic        anyWr;       // A write is pending.
   logic [1:0]  firstWr;     // Oldest pending write.

   // Next state of the retry sequencer. A snooped start is only taken
   // while idle; a second one during a sequence is left to the snoop.
   always_comb begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      ackSeen_d = ackSeen_q | bus.addrAck;
      unique case (state_q)
         RS_IDLE: begin
            ackSeen_d = 1'b0;
            if (bus.incomingTransferStart && snoopRetry) begin
               state_d = RS_WAIT;
               cnt_d   = 2'h1;
            end
         end
         RS_WAIT: begin
            cnt_d = cnt_q + 2'h1;
            if (cnt_q + 2'h1 == `SRDG_OE_DELAY) begin
               state_d = RS_OE;
            end
         end
         RS_OE: begin
            cnt_d = cnt_q + 2'h1;
            if (cnt_q + 2'h1 == `SRDG_OUT_DELAY) begin
               state_d = RS_ASSERT;
            end
         end
         RS_ASSERT: begin
            // Held through the acknowledge cycle, or one more cycle
            // when the acknowledge came early.
            if (bus.addrAck || ackSeen_q) begin
               state_d = RS_HOLD;
            end
         end
         RS_HOLD: begin
            state_d = RS_IDLE;
         end
         default: begin
            state_d = RS_IDLE;
         end
      endcase
   end

   // Retry sequencer registers. Outputs are computed from the next
   // state so they leave straight from flip-flops.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q      <= RS_IDLE;
         cnt_q        <= 2'h0;
         ackSeen_q    <= 1'b0;
         bus.retryOut <= 1'b0;
         bus.retryOeN <= 1'b1;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         ackSeen_q <= ackSeen_d;
         // Low in the hold cycle: driven negated before the float.
         bus.retryOut <= (state_d == RS_ASSERT);
         // Enable spans the hold cycle, so the pin is driven negated
         // for a cycle and floats only after that when tristate is on.
         bus.retryOeN <= ~(state_d == RS_OE || state_d == RS_ASSERT
                           || state_d == RS_HOLD);
      end
   end

   // Copy-back demand: the bus request rises on the edge that leaves
   // the hold cycle, two cycles after acknowledge.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         update_q   <= 1'b0;
         copyPend_q <= 1'b0;
      end else begin
         if (state_q == RS_IDLE && state_d == RS_WAIT) begin
            update_q <= snoopUpdate;
         end
         if (state_q == RS_HOLD && update_q) begin
            copyPend_q <= 1'b1;
         end else if (launch && copyPend_q) begin
            copyPend_q <= 1'b0;
         end
      end
   end

   // A grant starts the copy-back first, else the user's transfer.
   // No new start while the queue is full or our address is open.
   assign launch = bus.addressBusGrant && bus.addressBusRequest
                   && !ownAddr_q && qCnt_q != srdg_cnt_t'(QD);
   assign launchWr   = copyPend_q | xferWrite;
   assign launchData = copyPend_q | ~xferAddrOnly;

   // Address request and the outgoing transfer start. There is no
   // separate data request: a start with data queues a tenure.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.addressBusRequest     <= 1'b0;
         bus.outgoingTransferStart <= 1'b0;
         bus.xferIsWrite           <= 1'b0;
         bus.xferAddrOnly          <= 1'b0;
         ownAddr_q                 <= 1'b0;
         xferTaken                 <= 1'b0;
      end else begin
         bus.outgoingTransferStart <= launch;
         xferTaken <= launch & ~copyPend_q;
         if (launch) begin
            bus.xferIsWrite  <= launchWr;
            bus.xferAddrOnly <= ~launchData;
         end
         bus.addressBusRequest <= ~launch & ~bus.outgoingTransferStart
            & (copyPend_q | (state_q == RS_HOLD && update_q)
               | (xferReq & ~xferTaken));
         if (launch) begin
            ownAddr_q <= 1'b1;
         end else if (bus.addrAck) begin
            ownAddr_q <= 1'b0;
         end
      end
   end

   // Oldest pending write, for out-of-order write service.
   always_comb begin
      anyWr   = 1'b0;
      firstWr = 2'h0;
      for (int i = QD - 1; i >= 0; i--) begin
         if (qWr_q[i] && srdg_cnt_t'(i) < qCnt_q) begin
            anyWr   = 1'b1;
            firstWr = 2'(i);
         end
      end
   end

   // Grant is looked at only once a start has queued a tenure, and
   // only counts when the bus, data retry and own retry are all quiet.
   assign qualGrant = bus.dataBusGrant && qCnt_q != 3'h0
                      && !bus.dataBusBusyOut && !bus.dataRetry
                      && !bus.retryOut;
   // The hint is ignored unless a write waits.
   assign selIdx = (bus.writeOnly && anyWr) ? firstWr : 2'h0;
   assign enqPos = qualGrant ? 2'(qCnt_q - 3'h1) : 2'(qCnt_q);

   // Pending tenure queue, one process per slot; a served entry is
   // closed up by shifting the younger ones down.
   for (genvar g = 0; g < QD; g++) begin : gSlot
      always_ff @(posedge ref_clk or negedge arst_n) begin
         if (!arst_n) begin
            qWr_q[g] <= 1'b0;
         end else if (bus.outgoingTransferStart && !bus.xferAddrOnly
                      && enqPos == 2'(g)) begin
            qWr_q[g] <= bus.xferIsWrite;
         end else if (qualGrant && 2'(g) >= selIdx) begin
            qWr_q[g] <= (g < QD - 1) ? qWr_q[(g + 1) % QD] : 1'b0;
         end
      end
   end

   // Queue count follows enqueue and service.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         qCnt_q <= 3'h0;
      end else begin
         qCnt_q <= qCnt_q
            + ((bus.outgoingTransferStart && !bus.xferAddrOnly) ? 3'h1
                                                                  : 3'h0)
            - (qualGrant ? 3'h1 : 3'h0);
      end
   end

   // Data tenure: the core takes the bus on a qualified grant and
   // holds it until the final acknowledge.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.dataBusBusyOut <= 1'b0;
         tenureStart        <= 1'b0;
         tenureWrite        <= 1'b0;
         tenureDone         <= 1'b0;
      end else begin
         tenureStart <= qualGrant;
         tenureDone  <= bus.dataBusBusyOut & bus.finalTransferAck;
         if (qualGrant) begin
            bus.dataBusBusyOut <= 1'b1;
            tenureWrite        <= qWr_q[selIdx];
         end else if (bus.finalTransferAck) begin
            bus.dataBusBusyOut <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== hdl/srdg_map.svh
// Timing and sizing constants shared by both ends of the retry/grant link.
`ifndef SRDG_MAP_SVH
`define SRDG_MAP_SVH
// Bus cycles from incoming transfer start to retry output enable.
`define SRDG_OE_DELAY   2'h2
// Bus cycles from incoming transfer start to retry output.
`define SRDG_OUT_DELAY  2'h3
// Bus cycles from a transfer start to address acknowledge.
`define SRDG_AACK_LAT   3'h4
// Bus cycles from data bus busy to the final transfer acknowledge.
`define SRDG_BEATS      3'h4
// Depth of the pending data tenure queue.
`define SRDG_QDEPTH     4
// Width of the queue fill count.
`define SRDG_QCW        3
`endif

// ===== hdl/srdg_pkg.sv
// Types shared by the core end and the bus end.
package srdg_pkg;
   // States of the snoop retry sequencer.
   typedef enum logic [2:0] {
      RS_IDLE   = 3'h0,
      RS_WAIT   = 3'h1,
      RS_OE     = 3'h2,
      RS_ASSERT = 3'h3,
      RS_HOLD   = 3'h4
   } srdg_retry_e;
   // Queue fill count type.
   typedef logic [2:0] srdg_cnt_t;
endpackage

// ===== hdl/srdg_if.sv
// Link between the core end and the arbiter/snooper end.
`timescale 1ns/100ps
`default_nettype none
interface srdg_if;
   logic incomingTransferStart; // Another master starts an address tenure.
   logic addrAck;               // Address phase complete.
   logic retryOut;              // Core retry output, asserted high.
   logic retryOeN;              // Core retry output enable, low = driving.
   logic retryTre;              // Static high-impedance enable.
   logic retryFromOthers;       // Retry driven by other snoopers.
   logic retryLine;             // Resolved wired-OR retry line.
   logic outgoingTransferStart; // Core starts an address tenure.
   logic xferIsWrite;           // Attribute of the core's transfer.
   logic xferAddrOnly;          // Core transfer has no data tenure.
   logic addressBusRequest;     // Core asks for the address bus.
   logic addressBusGrant;       // One-cycle address bus grant.
   logic dataBusGrant;          // Raw data bus grant.
   logic dataRetry;             // Data retry input to the core.
   logic dataBusBusyOut;        // Core owns the data bus.
   logic writeOnly;             // Write-only data bus hint.
   logic finalTransferAck;      // Last beat of the core's data tenure.

   // The core output floats when enabled for tristate and not driving;
   // the line is then left to the other snoopers.
   assign retryLine = ((~retryTre | ~retryOeN) & retryOut)
                      | retryFromOthers;

   modport core (
      input  incomingTransferStart, addrAck, retryTre, retryLine,
      input  addressBusGrant, dataBusGrant, dataRetry, writeOnly,
      input  finalTransferAck,
      output retryOut, retryOeN, outgoingTransferStart, xferIsWrite,
      output xferAddrOnly, addressBusRequest, dataBusBusyOut
   );
   modport bus (
      output incomingTransferStart, addrAck, retryTre, retryFromOthers,
      output addressBusGrant, dataBusGrant, dataRetry, writeOnly,
      output finalTransferAck,
      input  retryLine, outgoingTransferStart, xferIsWrite, xferAddrOnly,
      input  addressBusRequest, dataBusBusyOut
   );
endinterface
`default_nettype wire

// ===== hdl/srdg_bus_end.sv
// Arbiter and snooping-master end of the retry/grant link.
`timescale 1ns/100ps
`default_nettype none
`include "srdg_map.svh"
module srdg_bus_end import srdg_pkg::*; (
   input  wire logic ref_clk,       // Bus clock.
   input  wire logic arst_n,        // Asynchronous reset, active low.
   srdg_if.bus       bus,           // Link to the core end.
   input  wire logic retryTriState, // Tristate setting, caught on the first edge after reset.
   input  wire logic snoopStartReq, // Start another master's tenure.
   input  wire logic otherRetry,    // Other snoopers drive retry.
   input  wire logic grantHold,     // Withhold the data bus grant.
   input  wire logic dataRetryReq,  // Drive data retry.
   input  wire logic writeOnlyReq,  // Drive the write-only hint.
   output logic      retrySeen,     // Pulse: retry seen in aack window.
   output logic      addrDone       // Pulse: an address phase ended.
);
   logic       cfgLock_q;  // Setting captured and frozen.
   logic       addrBusy_q; // An address tenure is open.
   logic [2:0] aCnt_q;     // Cycles since the transfer start.
   logic       aackDly_q;  // Address acknowledge one cycle ago.
   logic [2:0] dCnt_q;     // Cycles of the core's data tenure.
   logic       launch;     // Host starts a snooped tenure now.

   assign launch = snoopStartReq & ~addrBusy_q & ~bus.addressBusGrant
                   & ~bus.addressBusRequest;

   // The tristate setting is caught on the first edge after reset and
   // then never changes, so the core sees a static level.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfgLock_q    <= 1'b0;
         bus.retryTre <= 1'b0;
      end else if (!cfgLock_q) begin
         cfgLock_q    <= 1'b1;
         bus.retryTre <= retryTriState;
      end
   end

   // Address arbitration: a one-cycle grant while no tenure is open.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.addressBusGrant       <= 1'b0;
         bus.incomingTransferStart <= 1'b0;
      end else begin
         bus.addressBusGrant <= bus.addressBusRequest & ~addrBusy_q
            & ~bus.addressBusGrant & ~bus.outgoingTransferStart;
         bus.incomingTransferStart <= launch;
      end
   end

   // Address acknowledge comes a fixed time after either start.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         addrBusy_q  <= 1'b0;
         aCnt_q      <= 3'h0;
         bus.addrAck <= 1'b0;
         aackDly_q   <= 1'b0;
         addrDone    <= 1'b0;
      end else begin
         aackDly_q <= bus.addrAck;
         addrDone  <= bus.addrAck;
         if (bus.addrAck) begin
            // Negates one cycle after assertion; tenure closes.
            bus.addrAck <= 1'b0;
            addrBusy_q  <= 1'b0;
            aCnt_q      <= 3'h0;
         end else if (bus.incomingTransferStart
                      | bus.outgoingTransferStart) begin
            addrBusy_q <= 1'b1;
            aCnt_q     <= 3'h1;
         end else if (launch) begin
            addrBusy_q <= 1'b1;
         end else if (addrBusy_q && aCnt_q != 3'h0) begin
            aCnt_q      <= aCnt_q + 3'h1;
            bus.addrAck <= (aCnt_q == `SRDG_AACK_LAT - 3'h1);
         end
      end
   end

   // Retry is sampled with address acknowledge and one cycle later.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         retrySeen           <= 1'b0;
         bus.retryFromOthers <= 1'b0;
      end else begin
         retrySeen <= (bus.addrAck | aackDly_q) & bus.retryLine;
         bus.retryFromOthers <= otherRetry;
      end
   end

   // Data arbitration; the grant may move at any time.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.dataBusGrant     <= 1'b0;
         bus.dataRetry        <= 1'b0;
         bus.writeOnly        <= 1'b0;
         bus.finalTransferAck <= 1'b0;
         dCnt_q               <= 3'h0;
      end else begin
         bus.dataBusGrant <= ~grantHold & ~bus.dataBusBusyOut;
         bus.dataRetry    <= dataRetryReq;
         bus.writeOnly    <= writeOnlyReq;
         if (bus.finalTransferAck) begin
            bus.finalTransferAck <= 1'b0;
            dCnt_q               <= 3'h0;
         end else if (bus.dataBusBusyOut) begin
            dCnt_q <= dCnt_q + 3'h1;
            bus.finalTransferAck <= (dCnt_q == `SRDG_BEATS - 3'h1);
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/srdg_link_asserts.sv
// Concurrent checks on the retry and data grant link between both ends.
`timescale 1ns/100ps
`default_nettype none
module srdg_link_asserts (
   input wire logic ref_clk,               // Bus clock.
   input wire logic arst_n,                // Asynchronous reset, active low.
   input wire logic incomingTransferStart, // Another master starts.
   input wire logic addrAck,               // Address phase complete.
   input wire logic retryOut,              // Core retry output.
   input wire logic retryOeN,              // Core retry enable, active low.
   input wire logic retryTre,              // Static tristate enable.
   input wire logic retryFromOthers,       // Retry from other snoopers.
   input wire logic retryLine,             // Resolved retry line.
   input wire logic outgoingTransferStart, // Core starts a tenure.
   input wire logic addressBusRequest,     // Core address request.
   input wire logic dataBusGrant,          // Raw data bus grant.
   input wire logic dataRetry,             // Data retry.
   input wire logic dataBusBusyOut,        // Core owns the data bus.
   input wire logic finalTransferAck       // Last data beat.
);
   // All checks share the bus clock and its reset.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // Release of a retry: driven negated one cycle, then the enable drops.
   sequence releaseSeq;
      (!retryOut && !retryOeN) ##1 retryOeN;
   endsequence

   chk_oe_from_start: assert property (
      $fell(retryOeN) |-> $past(incomingTransferStart, 2))
      else $error("Retry enable rose without a start two cycles before.");
   chk_out_after_oe: assert property (
      $fell(retryOeN) |=> retryOut)
      else $error("Retry output did not follow its enable by one cycle.");
   chk_out_held_ack: assert property (
      retryOut && !addrAck |=> retryOut)
      else $error("Retry output dropped before address acknowledge.");
   chk_release_after_ack: assert property (
      retryOut && addrAck |=> releaseSeq)
      else $error("Retry release after acknowledge is out of step.");
   chk_out_needs_oe: assert property (
      retryOut |-> !retryOeN)
      else $error("Retry output asserted while not enabled.");
   chk_line_floats: assert property (
      retryTre && retryOeN |-> (retryLine == retryFromOthers))
      else $error("Floating core retry still reaches the line.");
   chk_busy_qualified: assert property (
      $rose(dataBusBusyOut) |-> $past(dataBusGrant && !dataRetry && !retryOut))
      else $error("Data bus taken without a qualified grant.");
   chk_busy_until_ack: assert property (
      dataBusBusyOut |=> (dataBusBusyOut != $past(finalTransferAck)))
      else $error("Data bus ownership did not end on the final beat.");
   chk_req_drops_start: assert property (
      outgoingTransferStart |-> !addressBusRequest)
      else $error("Address request stayed up with the transfer start.");
   chk_reset_idle: assert property (
      $rose(arst_n) |-> retryOeN && !retryOut && !dataBusBusyOut)
      else $error("Retry or busy active right after reset.");
endmodule
`default_nettype wire

// ===== sim/snoop_retry_data_grant_tb_top.sv
// Self-checking bench joining the core end and the bus end.
`timescale 1ns/100ps
`default_nettype none
module snoop_retry_data_grant_tb_top import srdg_pkg::*;;
   logic ref_clk, arst_n, retryTriState, snoopStartReq, otherRetry;
   logic grantHold, dataRetryReq, writeOnlyReq, snoopRetry, snoopUpdate;
   logic xferReq, xferWrite, addrOnlyReq, retrySeen, addrDone;
   logic xferTaken, tenureStart, tenureWrite, tenureDone;
   int   errCount, numChecks, cycleCount, tenureCount, savedCount;

   srdg_if srdg_if_i ();
   srdg_bus_end srdg_bus_end_i (.ref_clk(ref_clk), .arst_n(arst_n),
      .bus(srdg_if_i), .retryTriState(retryTriState),
      .snoopStartReq(snoopStartReq), .otherRetry(otherRetry),
      .grantHold(grantHold), .dataRetryReq(dataRetryReq),
      .writeOnlyReq(writeOnlyReq), .retrySeen(retrySeen),
      .addrDone(addrDone));
   srdg_core_end srdg_core_end_i (.ref_clk(ref_clk), .arst_n(arst_n),
      .bus(srdg_if_i), .snoopRetry(snoopRetry), .snoopUpdate(snoopUpdate),
      .xferReq(xferReq), .xferWrite(xferWrite), .xferAddrOnly(addrOnlyReq),
      .xferTaken(xferTaken), .tenureStart(tenureStart),
      .tenureWrite(tenureWrite), .tenureDone(tenureDone));
   srdg_link_asserts srdg_link_asserts_i (.ref_clk(ref_clk),
      .arst_n(arst_n), .incomingTransferStart(srdg_if_i.incomingTransferStart),
      .addrAck(srdg_if_i.addrAck), .retryOut(srdg_if_i.retryOut),
      .retryOeN(srdg_if_i.retryOeN), .retryTre(srdg_if_i.retryTre),
      .retryFromOthers(srdg_if_i.retryFromOthers),
      .retryLine(srdg_if_i.retryLine),
      .outgoingTransferStart(srdg_if_i.outgoingTransferStart),
      .addressBusRequest(srdg_if_i.addressBusRequest),
      .dataBusGrant(srdg_if_i.dataBusGrant), .dataRetry(srdg_if_i.dataRetry),
      .dataBusBusyOut(srdg_if_i.dataBusBusyOut),
      .finalTransferAck(srdg_if_i.finalTransferAck));

   // Free-running bus clock, 100 ns period.
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Counts data tenures and cuts a hang short well past the expected run.
   always @(posedge ref_clk) begin
      cycleCount++;
      if (tenureStart === 1'b1) begin
         tenureCount++;
      end
      if (cycleCount == 3000) begin
         errCount++;
         endOfTest;
      end
   end

   // Compares one bit; an unknown never matches.
   task automatic check(input logic got, input logic exp);
      numChecks++;
      if (got !== exp) begin
         errCount++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Moves to just after the next rising edge, where outputs have settled.
   task automatic nextCyc;
      @(posedge ref_clk);
      #1;
   endtask

   // Waits, bounded, for a start, a taken transfer, a tenure start or end.
   task automatic waitFor(input int sel);
      int n = 0;
      #1;
      while (!(sel == 0 ? srdg_if_i.incomingTransferStart === 1'b1 :
               sel == 1 ? xferTaken === 1'b1 :
               sel == 2 ? tenureStart === 1'b1 : tenureDone === 1'b1)
             && n < 60) begin
         nextCyc;
         n++;
      end
      check(n < 60, 1'b1);
   endtask

   // Another master starts a tenure; the cycle walk is checked from c1.
   task automatic snoop(input logic rt, input logic upd);
      @(posedge ref_clk) snoopStartReq <= 1'b1;
      snoopRetry <= rt;
      snoopUpdate <= upd;
      @(posedge ref_clk) snoopStartReq <= 1'b0;
      waitFor(0);
      @(posedge ref_clk) snoopRetry <= 1'b0;
      snoopUpdate <= 1'b0;
      #1;
      check(srdg_if_i.retryOeN, 1'b1);
      nextCyc;
      check(srdg_if_i.retryOeN, !rt);
      nextCyc;
      check(srdg_if_i.retryOut, rt);
      check(srdg_if_i.retryLine, rt);
      nextCyc;
      check(srdg_if_i.addrAck, 1'b1);
      check(srdg_if_i.retryOut, rt);
      nextCyc;
      check(srdg_if_i.retryOut, 1'b0);
      check(srdg_if_i.retryOeN, !rt);
      check(addrDone, 1'b1);
      check(retrySeen, rt);
      nextCyc;
      check(srdg_if_i.retryOeN, 1'b1);
      check(srdg_if_i.retryLine, 1'b0);
      check(srdg_if_i.addressBusRequest, rt & upd);
   endtask

   // Issues one core transfer and drops the request once it is taken.
   task automatic issue(input logic wr, input logic ao);
      @(posedge ref_clk) xferReq <= 1'b1;
      xferWrite <= wr;
      addrOnlyReq <= ao;
      waitFor(1);
      @(posedge ref_clk) xferReq <= 1'b0;
   endtask

   // Main sequence; the tristate setting is fixed before reset ends.
   initial begin
      {snoopStartReq, otherRetry, grantHold, dataRetryReq} = 4'h0;
      {writeOnlyReq, snoopRetry, snoopUpdate, xferReq} = 4'h0;
      {xferWrite, addrOnlyReq} = 2'h0;
      retryTriState = 1'b1;
      arst_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      nextCyc;
      check(srdg_if_i.retryOeN, 1'b1);
      snoop(1'b1, 1'b0);
      snoop(1'b0, 1'b0);
      snoop(1'b1, 1'b1);
      waitFor(2);
      check(tenureWrite, 1'b1);
      waitFor(3);
      // A held grant keeps both tenures back; then the write jumps ahead.
      @(posedge ref_clk) grantHold <= 1'b1;
      issue(1'b0, 1'b0);
      issue(1'b1, 1'b0);
      repeat (8) nextCyc;
      check(srdg_if_i.dataBusBusyOut, 1'b0);
      @(posedge ref_clk) dataRetryReq <= 1'b1;
      writeOnlyReq <= 1'b1;
      grantHold <= 1'b0;
      repeat (8) nextCyc;
      check(srdg_if_i.dataBusBusyOut, 1'b0);
      @(posedge ref_clk) dataRetryReq <= 1'b0;
      waitFor(2);
      check(tenureWrite, 1'b1);
      // The hint stays up: with only a read left it must be ignored.
      waitFor(3);
      waitFor(2);
      check(tenureWrite, 1'b0);
      @(posedge ref_clk) writeOnlyReq <= 1'b0;
      waitFor(3);
      // An address-only transfer must not claim the data bus.
      savedCount = tenureCount;
      issue(1'b1, 1'b1);
      repeat (15) nextCyc;
      check(tenureCount == savedCount, 1'b1);
      // Other snoopers alone drive the line while the core floats.
      @(posedge ref_clk) otherRetry <= 1'b1;
      repeat (3) nextCyc;
      check(srdg_if_i.retryLine, 1'b1);
      @(posedge ref_clk) otherRetry <= 1'b0;
      repeat (3) nextCyc;
      check(srdg_if_i.retryLine, 1'b0);
      // Reset again in mid-run with tristate off; the setting may only
      // change while reset is held, and retry is then always driven.
      @(posedge ref_clk) arst_n <= 1'b0;
      retryTriState <= 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      nextCyc;
      check(srdg_if_i.retryOeN, 1'b1);
      check(srdg_if_i.retryTre, 1'b0);
      snoop(1'b1, 1'b0);
      endOfTest;
   end

   // Prints the counts and the verdict, then stops the run.
   task endOfTest;
      $display("checks %0d mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
endmodule
`default_nettype wire
